// *** rtl/dacr_alert_timer.sv ***
// Alert qualifier: debounce before assertion, minimum hold once asserted.
// Assumes counts are stable while a trigger is being qualified.
`timescale 1ns/1ps
module dacr_alert_timer #(
	parameter int CW = 24
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic trig,
	input wire logic [CW-1:0] deb_cyc,
	input wire logic [CW-1:0] hold_cyc,
	output logic alert
);
	typedef enum logic [1:0] {ST_IDLE, ST_DEB, ST_HOLD, ST_WAIT} dacr_tmr_e;

	dacr_tmr_e state_reg;
	logic [CW-1:0] cnt_reg;

	// Debounce, hold, then wait for the trigger to go away
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
		end else if (ce) begin
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= '0;
					if (trig) begin
						state_reg <= ST_DEB;
					end
				end
				ST_DEB: begin
					if (!trig) begin
						state_reg <= ST_IDLE;
					end else if (cnt_reg >= deb_cyc) begin
						state_reg <= ST_HOLD;
						cnt_reg <= '0;
					end else begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_HOLD: begin
					if (cnt_reg >= hold_cyc) begin
						state_reg <= trig ? ST_WAIT : ST_IDLE; // R23
					end else begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_WAIT: begin
					if (!trig) begin
						state_reg <= ST_IDLE; // R23
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign alert = (state_reg == ST_HOLD) || (state_reg == ST_WAIT);
endmodule : dacr_alert_timer

// *** rtl/dacr_pkg.sv ***
// Package: command codes, field positions, reset values, timing and carrier types.
// Assumes a 40 MHz CLK and an upstream SMBus engine that decodes write-word/read-word.
package dacr_pkg;
	// Command codes of the registers in this block
	localparam logic [7:0] CMD_CFG_PRI = 8'h39;
	localparam logic [7:0] CMD_INFO = 8'h3A;
	localparam logic [7:0] CMD_CFG_SEC = 8'h3C;
	localparam logic [7:0] CMD_CFG_THIRD = 8'h3D;
	localparam logic [7:0] CMD_DC_THR = 8'h48;
	localparam logic [7:0] CMD_CFG_FOURTH = 8'h4C;
	localparam logic [7:0] CMD_CFG_FIFTH = 8'h4E;
	// Charge voltage limit, watched for the bus-inactivity timer
	localparam logic [7:0] CMD_CHG_VOLT = 8'h15;

	// Discharge alert threshold register
	localparam logic [15:0] DC_THR_RESET = 16'h1000;
	localparam int DC_THR_LSB = 8;
	localparam int DC_THR_MSB = 13;
	localparam int DC_THR_W = 6;
	localparam logic [5:0] DC_THR_MAX = 6'h32;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;

	// Field positions in config_primary
	localparam int PRI_FWD_LSB = 13;
	localparam int PRI_BOOST_LSB = 10;
	localparam int PRI_REV_LSB = 8;
	localparam int PRI_TMO_DIS_BIT = 7;
	localparam int PRI_SHORT_LSB = 5;
	localparam int PRI_LP_LSB = 3;
	// Field positions in config_second, config_third and info_status
	localparam int SEC_SYSTEM_POWER_MONITOR_BIT = 3;
	localparam int THIRD_DEB_LSB = 9;
	localparam int THIRD_HOLD_LSB = 6;
	localparam int INFO_REF_BIT = 15;

	// Timing
	localparam int CLK_KHZ = 40000;
	localparam int LOW_VSYS_DEB_US = 10;
	localparam int LOW_VSYS_DEB_CYC = (LOW_VSYS_DEB_US * CLK_KHZ + 999) / 1000;
	localparam int TMO_S = 175;
	localparam int TMO_MS = TMO_S * 1000;
	localparam int MS_CYC = CLK_KHZ;
	localparam int CNT_W = 24;

	// Request from the SMBus engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [15:0] data;
	} dacr_req_s;

	// Decoded analog trims from config_primary
	typedef struct packed {
		logic signed [3:0] fwd_ofs_hmv;
		logic signed [3:0] boost_ofs_hmv;
		logic [1:0] rev_ofs_code;
		logic [9:0] short_mv;
		logic tmo_en;
	} dacr_cfg_s;

	// Offset code to signed half-millivolt steps
	function automatic logic signed [3:0] ofs_hmv(input logic [2:0] code);
		ofs_hmv = {code[2], code};
	endfunction : ofs_hmv

	// Short-detect threshold in mV
	function automatic logic [9:0] short_mv(input logic [1:0] code);
		case (code)
			2'h0: short_mv = 10'h190;
			2'h1: short_mv = 10'h1F4;
			2'h2: short_mv = 10'h258;
			default: short_mv = 10'h320;
		endcase
	endfunction : short_mv

	// Low-power discharge threshold in mA
	function automatic logic [15:0] lp_thr_ma(input logic [1:0] code);
		case (code)
			2'h0: lp_thr_ma = 16'h2EE0;
			2'h1: lp_thr_ma = 16'h2710;
			2'h2: lp_thr_ma = 16'h1F40;
			default: lp_thr_ma = 16'h1770;
		endcase
	endfunction : lp_thr_ma
endpackage : dacr_pkg

// *** rtl/dacr_top.sv ***
// Discharge alert threshold, control registers, processor-hot alert and bus timer.
// Assumes an SMBus engine that hands over decoded word transfers one cycle each,
// and analog front ends that report discharge current in mA and a low-VSYS level.
`timescale 1ns/1ps
// Functional notes
// R1: Host writes the discharge threshold with a write-word at code 0x48.
// R2: Each threshold step weighs 256 mA.
// R3: Any word accepted; only bits 13:8 stored, rest ignored.
// R4: Stored threshold clamps at field 110010, i.e. 12.8 A.
// R5: Threshold register resets to 0x1000.
// R6: Reading the threshold register returns its stored contents.
// R7: Over-current asserts alert after programmed debounce, held for programmed duration.
// R8: Low system voltage alert uses a fixed 10 us debounce.
// R9: Battery-only low-power operation takes threshold from config_primary bits 4:3.
// R10: Battery-only alerting works only while the power monitor is enabled; the low-VSYS alert here also fires with it disabled.
// R11: info_status bit 15 shows whether the comparator reference is active.
// R12: Comparator reference is always active while an adapter is present.
// R13: With power monitor enabled, the threshold register sets the alert level.
// R14: Host writes config_primary at 0x39, second and third at 0x3C, 0x3D.
// R15: Host writes fourth and fifth config registers at 0x4C and 0x4E.
// R16: Bits 15:13 give forward buck offset, signed 0.5 mV steps.
// R17: Bits 12:10 give boost offset with the same signed code set.
// R18: Bits 9:8 give reverse buck offset, 00 meaning zero.
// R19: With adapter and timer enabled, stop charging after 175 s without limit writes.
// R20: A charge voltage or current limit write resumes charging after timeout.
// R21: config_primary bit 7 low enables the bus timer, high disables it.
// R22: Bits 6:5 select short-detect threshold 400, 500, 600 or 800 mV.
// R23: Alert releases only after hold time and once over-current has cleared.
module dacr_top #(
	parameter int DEB_UNIT_CYC = 400,
	parameter int HOLD_UNIT_CYC = 40000,
	parameter int TICK_CYC = dacr_pkg::MS_CYC,
	parameter int TMO_TICKS = dacr_pkg::TMO_MS,
	parameter logic [7:0] CMD_CHG_CUR = 8'h00
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire dacr_pkg::dacr_req_s REG_REQ,
	output logic [15:0] REG_RDATA,
	output logic REG_RVALID,
	output logic REG_NACK,
	input wire logic ADAPTER_PRESENT,
	input wire logic LOW_POWER_MODE,
	input wire logic [15:0] DISCHG_MA,
	input wire logic LOW_VSYS,
	output logic ALERT_PIN_O,
	output logic ALERT_PIN_OE_N,
	output logic [15:0] DC_THR_MA,
	output logic COMP_REF_ACTIVE,
	output logic CHARGE_EN,
	output logic TIMED_OUT,
	output dacr_pkg::dacr_cfg_s CFG_TRIM
);
	localparam int CW = dacr_pkg::CNT_W;
	// Field widths inside the control registers
	localparam int DEB_W = 2;
	localparam int HOLD_W = 3;
	localparam int OFS_W = 3;
	localparam int REV_W = 2;
	localparam int SEL_W = 2;

	// Write strobe for one command code
	function automatic logic wr_hit(input dacr_pkg::dacr_req_s req, input logic [7:0] code);
		wr_hit = req.wr && (req.cmd == code);
	endfunction : wr_hit

	// Stored threshold field placed at its bits of the register word
	function automatic logic [15:0] thr_word(input logic [dacr_pkg::DC_THR_W-1:0] field);
		thr_word = 16'(field) << dacr_pkg::DC_THR_LSB;
	endfunction : thr_word

	// Register storage
	logic [dacr_pkg::DC_THR_W-1:0] dc_thr_reg;
	logic [15:0] cfg_pri_reg;
	logic [15:0] cfg_sec_reg;
	logic [15:0] cfg_third_reg;
	logic [15:0] cfg_fourth_reg;
	logic [15:0] cfg_fifth_reg;

	// Decoded write strobes
	logic wr_dc_thr;
	logic wr_pri;
	logic wr_sec;
	logic wr_third;
	logic wr_fourth;
	logic wr_fifth;
	logic wr_limit;
	logic wr_info;
	logic [dacr_pkg::DC_THR_W-1:0] dc_thr_next;

	// Alert path
	logic system_power_monitor_en;
	logic ref_active;
	logic lp_select;
	logic [15:0] thr_ma_next;
	logic over_current;
	logic dc_alert;
	logic vsys_alert;
	logic [CW-1:0] deb_cyc;
	logic [CW-1:0] hold_cyc;
	logic alert_reg;

	// Bus timer
	logic [CW-1:0] tick_reg;
	logic [CW-1:0] ms_reg;
	logic tick_wrap;
	logic tmo_run;
	logic tmo_fire;
	logic timed_out_reg;

	// Read path
	logic [15:0] rdata_next;
	logic rd_hit;
	logic rd_taken;

	// Write decode; codes per register map
	assign wr_dc_thr = wr_hit(REG_REQ, dacr_pkg::CMD_DC_THR); // R1
	assign wr_pri = wr_hit(REG_REQ, dacr_pkg::CMD_CFG_PRI); // R14
	assign wr_sec = wr_hit(REG_REQ, dacr_pkg::CMD_CFG_SEC); // R14
	assign wr_third = wr_hit(REG_REQ, dacr_pkg::CMD_CFG_THIRD); // R14
	assign wr_fourth = wr_hit(REG_REQ, dacr_pkg::CMD_CFG_FOURTH); // R15
	assign wr_fifth = wr_hit(REG_REQ, dacr_pkg::CMD_CFG_FIFTH); // R15
	assign wr_info = wr_hit(REG_REQ, dacr_pkg::CMD_INFO);
	assign wr_limit = wr_hit(REG_REQ, dacr_pkg::CMD_CHG_VOLT)
		|| wr_hit(REG_REQ, CMD_CHG_CUR); // R19 R20

	// Keep only the threshold field and clamp it
	always_comb begin
		dc_thr_next = REG_REQ.data[dacr_pkg::DC_THR_MSB:dacr_pkg::DC_THR_LSB]; // R3
		if (dc_thr_next > dacr_pkg::DC_THR_MAX) begin
			dc_thr_next = dacr_pkg::DC_THR_MAX; // R4
		end
	end

	// Discharge threshold register
	always_ff @(posedge CLK) begin
		if (SRST) begin
			dc_thr_reg <= dacr_pkg::DC_THR_RESET[dacr_pkg::DC_THR_MSB:dacr_pkg::DC_THR_LSB]; // R5
		end else if (CE && wr_dc_thr) begin
			dc_thr_reg <= dc_thr_next; // R3
		end
	end

	// Control registers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cfg_pri_reg <= dacr_pkg::CFG_RESET;
			cfg_sec_reg <= dacr_pkg::CFG_RESET;
			cfg_third_reg <= dacr_pkg::CFG_RESET;
			cfg_fourth_reg <= dacr_pkg::CFG_RESET;
			cfg_fifth_reg <= dacr_pkg::CFG_RESET;
		end else if (CE) begin
			if (wr_pri) begin
				cfg_pri_reg <= REG_REQ.data; // R14
			end
			if (wr_sec) begin
				cfg_sec_reg <= REG_REQ.data; // R14
			end
			if (wr_third) begin
				cfg_third_reg <= REG_REQ.data; // R14
			end
			if (wr_fourth) begin
				cfg_fourth_reg <= REG_REQ.data; // R15
			end
			if (wr_fifth) begin
				cfg_fifth_reg <= REG_REQ.data; // R15
			end
		end
	end

	// Comparator reference and threshold selection
	assign system_power_monitor_en = cfg_sec_reg[dacr_pkg::SEC_SYSTEM_POWER_MONITOR_BIT];
	assign ref_active = ADAPTER_PRESENT || system_power_monitor_en; // R10 R12
	assign lp_select = !ADAPTER_PRESENT && LOW_POWER_MODE && !system_power_monitor_en; // R9 R13

	// Threshold in mA, register field weighs one 256 mA step per code
	always_comb begin
		if (lp_select) begin
			thr_ma_next = dacr_pkg::lp_thr_ma(
				cfg_pri_reg[dacr_pkg::PRI_LP_LSB +: SEL_W]); // R9
		end else begin
			thr_ma_next = thr_word(dc_thr_reg); // R2 R13
		end
	end

	// Over-current only counts while the reference is up
	assign over_current = ref_active && (DISCHG_MA > thr_ma_next); // R10

	// Debounce and hold lengths from config_third
	assign deb_cyc = CW'(DEB_UNIT_CYC * int'(cfg_third_reg[dacr_pkg::THIRD_DEB_LSB +: DEB_W]));
	assign hold_cyc = CW'(HOLD_UNIT_CYC
		* (int'(cfg_third_reg[dacr_pkg::THIRD_HOLD_LSB +: HOLD_W]) + 1));

	// Discharge over-current qualifier
	dacr_alert_timer #(
		.CW(CW)
	) u_dc_timer (
		.clk(CLK),
		.srst(SRST),
		.ce(CE),
		.trig(over_current),
		.deb_cyc(deb_cyc), // R7
		.hold_cyc(hold_cyc), // R7
		.alert(dc_alert)
	);

	// Low system voltage qualifier, fixed debounce
	dacr_alert_timer #(
		.CW(CW)
	) u_vsys_timer (
		.clk(CLK),
		.srst(SRST),
		.ce(CE),
		.trig(LOW_VSYS),
		.deb_cyc(CW'(dacr_pkg::LOW_VSYS_DEB_CYC)), // R8
		.hold_cyc(hold_cyc),
		.alert(vsys_alert)
	);

	// Alert pin register, open drain pulls low while asserted
	always_ff @(posedge CLK) begin
		if (SRST) begin
			alert_reg <= 1'b0;
		end else if (CE) begin
			alert_reg <= dc_alert || vsys_alert; // R7
		end
	end

	assign ALERT_PIN_O = 1'b0;
	assign ALERT_PIN_OE_N = !alert_reg;

	// Last cycle of each millisecond
	assign tick_wrap = (tick_reg == CW'(TICK_CYC - 1));

	// Millisecond prescaler for the bus timer
	assign tmo_run = ADAPTER_PRESENT && !cfg_pri_reg[dacr_pkg::PRI_TMO_DIS_BIT] // R21
		&& !timed_out_reg;
	assign tmo_fire = tmo_run && tick_wrap
		&& (ms_reg == CW'(TMO_TICKS - 1)); // R19

	always_ff @(posedge CLK) begin
		if (SRST) begin
			tick_reg <= '0;
		end else if (CE) begin
			if (!tmo_run || wr_limit || tick_wrap) begin
				tick_reg <= '0;
			end else begin
				tick_reg <= tick_reg + 1'b1;
			end
		end
	end

	// Elapsed milliseconds since the last limit write
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ms_reg <= '0;
		end else if (CE) begin
			if (!tmo_run || wr_limit) begin
				ms_reg <= '0; // R19
			end else if (tick_wrap) begin
				ms_reg <= ms_reg + 1'b1;
			end
		end
	end

	// Timeout flag; expiry wins over a same-cycle limit write
	always_ff @(posedge CLK) begin
		if (SRST) begin
			timed_out_reg <= 1'b0;
		end else if (CE) begin
			if (tmo_fire) begin
				timed_out_reg <= 1'b1; // R19
			end else if (wr_limit) begin
				timed_out_reg <= 1'b0; // R20
			end
		end
	end

	// Read mux
	always_comb begin
		rd_hit = 1'b1;
		rdata_next = dacr_pkg::ZERO16;
		case (REG_REQ.cmd)
			dacr_pkg::CMD_DC_THR: rdata_next = thr_word(dc_thr_reg); // R6
			dacr_pkg::CMD_CFG_PRI: rdata_next = cfg_pri_reg;
			dacr_pkg::CMD_CFG_SEC: rdata_next = cfg_sec_reg;
			dacr_pkg::CMD_CFG_THIRD: rdata_next = cfg_third_reg;
			dacr_pkg::CMD_CFG_FOURTH: rdata_next = cfg_fourth_reg;
			dacr_pkg::CMD_CFG_FIFTH: rdata_next = cfg_fifth_reg;
			dacr_pkg::CMD_INFO: rdata_next[dacr_pkg::INFO_REF_BIT] = ref_active; // R11
			default: rd_hit = 1'b0;
		endcase
	end

	// Read accepted this cycle
	assign rd_taken = REG_REQ.rd && rd_hit;

	// Read answer one cycle after the request
	always_ff @(posedge CLK) begin
		if (SRST) begin
			REG_RDATA <= dacr_pkg::ZERO16;
			REG_RVALID <= 1'b0;
		end else if (CE) begin
			REG_RVALID <= rd_taken; // R6
			if (rd_taken) begin
				REG_RDATA <= rdata_next;
			end
		end
	end

	// Refusal of unmapped reads and of writes to the read-only status
	always_ff @(posedge CLK) begin
		if (SRST) begin
			REG_NACK <= 1'b0;
		end else if (CE) begin
			REG_NACK <= (REG_REQ.rd && !rd_hit)
				|| wr_info; // R11
		end
	end

	// Registered status and decoded trim outputs
	always_ff @(posedge CLK) begin
		if (SRST) begin
			DC_THR_MA <= dacr_pkg::ZERO16;
			COMP_REF_ACTIVE <= 1'b0;
			CHARGE_EN <= 1'b0;
			TIMED_OUT <= 1'b0;
			CFG_TRIM <= '0;
		end else if (CE) begin
			DC_THR_MA <= thr_ma_next;
			COMP_REF_ACTIVE <= ref_active; // R11
			CHARGE_EN <= !timed_out_reg; // R19 R20
			TIMED_OUT <= timed_out_reg;
			CFG_TRIM.fwd_ofs_hmv <= dacr_pkg::ofs_hmv(
				cfg_pri_reg[dacr_pkg::PRI_FWD_LSB +: OFS_W]); // R16
			CFG_TRIM.boost_ofs_hmv <= dacr_pkg::ofs_hmv(
				cfg_pri_reg[dacr_pkg::PRI_BOOST_LSB +: OFS_W]); // R17
			CFG_TRIM.rev_ofs_code <= cfg_pri_reg[dacr_pkg::PRI_REV_LSB +: REV_W]; // R18
			CFG_TRIM.short_mv <= dacr_pkg::short_mv(
				cfg_pri_reg[dacr_pkg::PRI_SHORT_LSB +: SEL_W]); // R22
			CFG_TRIM.tmo_en <= !cfg_pri_reg[dacr_pkg::PRI_TMO_DIS_BIT]; // R21
		end
	end
endmodule : dacr_top

// *** tb/dacr_host_model.sv ***
// Host model: issues decoded word transfers to the register port.
// Assumes the block takes a request at one rising clock edge.
`timescale 1ns/1ps
module dacr_host_model (
	input wire logic clk,
	output dacr_pkg::dacr_req_s req
);
	// Idle bus at time zero
	initial req = '0;
	// One transfer held for its taking edge, then released with scrambled data
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: w, rd: !w, cmd: c, data: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d};
	endtask : xfer
endmodule : dacr_host_model

// *** tb/dacr_tb_top.sv ***
// Testbench of dacr_top with shortened counts and a host model.
// Assumes nothing outside; read answers checked from an expectation queue.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin miscompares++; \
	$display("ERROR %s exp %0h got %0h", nm, ex, gt); end end
module dacr_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic adp = 1'b0;
	logic lpm = 1'b0;
	logic vsys = 1'b0;
	logic [15:0] dis = 16'h0000;
	dacr_pkg::dacr_req_s req;
	dacr_pkg::dacr_cfg_s trim;
	logic [15:0] rdata, thr_ma, d;
	logic rvalid, nack, pin_o, oe_n, ref_act, chg_en, tmo;
	logic [5:0] f;
	logic [16:0] exp_v;
	logic [16:0] expq[$];
	logic [9:0] sm [4] = '{10'h190, 10'h1F4, 10'h258, 10'h320};
	logic [15:0] lpt [4] = '{16'h2EE0, 16'h2710, 16'h1F40, 16'h1770};
	int miscompares = 0;
	int tests_run = 0;
	int seed = 32'he869;
	int cyc = 0;
	// Open-drain alert line with pull-up
	wire alert_n = oe_n ? 1'b1 : pin_o;
	always #12.5 clk = ~clk;
	dacr_top #(.DEB_UNIT_CYC(2), .HOLD_UNIT_CYC(4), .TICK_CYC(2), .TMO_TICKS(50))
		u_dut (.CLK(clk), .SRST(srst), .CE(ce), .REG_REQ(req),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_NACK(nack), .ADAPTER_PRESENT(adp),
		.LOW_POWER_MODE(lpm), .DISCHG_MA(dis), .LOW_VSYS(vsys), .ALERT_PIN_O(pin_o),
		.ALERT_PIN_OE_N(oe_n), .DC_THR_MA(thr_ma), .COMP_REF_ACTIVE(ref_act),
		.CHARGE_EN(chg_en), .TIMED_OUT(tmo), .CFG_TRIM(trim));
	dacr_host_model u_host (.clk(clk), .req(req));
	task automatic end_sim();
		if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic cw(input int n);
		repeat (n) @(negedge clk);
	endtask : cw
	task automatic wrw(input logic [7:0] c, input logic [15:0] dd);
		u_host.xfer(1'b1, c, dd);
	endtask : wrw
	task automatic rd(input logic [7:0] c, input logic [16:0] e);
		expq.push_back(e);
		u_host.xfer(1'b0, c, 16'h0000);
		cw(1);
	endtask : rd
	// Each answer against the oldest expectation
	always @(negedge clk) begin
		if (rvalid === 1'b1 || nack === 1'b1) begin
			exp_v = (expq.size() > 0) ? expq.pop_front() : 17'h1FFFF;
			`CHK("read answer", exp_v, {nack, nack ? 16'h0000 : rdata})
		end
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			miscompares++;
			end_sim();
		end
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(8'h48, 17'h01000);
		foreach (lpt[i]) rd(8'h39 + 8'(i), (i == 2) ? 17'h10000 : 17'h00000);
		rd(8'h3D, 17'h00000);
		expq.push_back(17'h10000);
		wrw(8'h3A, 16'hFFFF);
		d = 16'($random(seed));
		wrw(8'h4C, d);
		rd(8'h4C, {1'b0, d});
		wrw(8'h4E, ~d);
		rd(8'h4E, {1'b0, ~d});
		for (int i = 0; i < 10; i++) begin
			d = (i == 0) ? 16'hFFFF : 16'($random(seed));
			f = (d[13:8] > 6'h32) ? 6'h32 : d[13:8];
			wrw(8'h48, d);
			rd(8'h48, {3'h0, f, 8'h00});
			`CHK("thr ma", {2'h0, f, 8'h00}, thr_ma)
		end
		for (int i = 0; i < 8; i++) begin
			d = {i[2:0], ~i[2:0], i[1:0], i[0], i[1:0], 5'h00};
			wrw(8'h39, d);
			rd(8'h39, {1'b0, d});
			`CHK("trim", {i[2], i[2:0], ~i[2], ~i[2:0], i[1:0], sm[i[1:0]], ~i[0]}, trim)
		end
		@(posedge clk) adp <= 1'b1;
		rd(8'h3A, 17'h08000);
		`CHK("ref active", 1'b1, ref_act)
		@(posedge clk) adp <= 1'b0;
		wrw(8'h3C, 16'h0008);
		rd(8'h3A, 17'h08000);
		wrw(8'h3C, 16'h0000);
		rd(8'h3A, 17'h00000);
		`CHK("ref idle", 1'b0, ref_act)
		@(posedge clk) lpm <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wrw(8'h39, {8'h00, 1'b1, 2'h0, i[1:0], 3'h0});
			cw(3);
			`CHK("low power thr", lpt[i], thr_ma)
		end
		@(posedge clk) dis <= 16'hFFFF;
		cw(30);
		`CHK("no reference", 1'b1, alert_n)
		@(posedge clk) {adp, lpm, dis} <= {2'b10, 16'h0000};
		wrw(8'h3D, 16'h0480);
		wrw(8'h48, 16'h0400);
		@(posedge clk) ce <= 1'b0;
		wrw(8'h48, 16'h2000);
		@(posedge clk) ce <= 1'b1;
		rd(8'h48, 17'h00400);
		repeat (20) begin
			@(posedge clk) dis <= {6'h00, 10'($random(seed))};
			@(negedge clk) `CHK("below thr", 1'b1, alert_n)
		end
		@(posedge clk) dis <= 16'h0401;
		cw(4);
		`CHK("debounce", 1'b1, alert_n)
		cw(5);
		`CHK("alert", 1'b0, alert_n)
		cw(30);
		`CHK("still over", 1'b0, alert_n)
		@(posedge clk) dis <= 16'h0000;
		cw(5);
		`CHK("released", 1'b1, alert_n)
		@(posedge clk) dis <= 16'h0401;
		cw(9);
		@(posedge clk) dis <= 16'h0000;
		cw(8);
		`CHK("hold", 1'b0, alert_n)
		cw(10);
		`CHK("hold over", 1'b1, alert_n)
		@(posedge clk) vsys <= 1'b1;
		cw(390);
		`CHK("vsys debounce", 1'b1, alert_n)
		cw(20);
		`CHK("vsys alert", 1'b0, alert_n)
		@(posedge clk) vsys <= 1'b0;
		cw(20);
		wrw(8'h39, 16'h0000);
		cw(80);
		`CHK("early timeout", 1'b0, tmo)
		cw(40);
		`CHK("stopped", 2'b10, {tmo, chg_en})
		wrw(8'h15, 16'h1234);
		cw(4);
		`CHK("resumed", 2'b01, {tmo, chg_en})
		cw(110);
		wrw(8'h00, 16'h0100);
		cw(4);
		`CHK("resumed cur", 2'b01, {tmo, chg_en})
		wrw(8'h39, 16'h0080);
		cw(150);
		`CHK("disabled", 2'b01, {tmo, chg_en})
		cw(3);
		`CHK("queue empty", 0, expq.size())
		end_sim();
	end
endmodule : dacr_tb_top

// *** tb/dacr_top_sva.sv ***
// Checker of the register port, alert pin and bus timer of dacr_top.
// Assumes checks pause while CE is low; bound to every dacr_top instance.
`timescale 1ns/1ps
module dacr_top_sva #(
	parameter int HOLD_UNIT_CYC = 40000
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	input wire dacr_pkg::dacr_req_s REG_REQ,
	input wire logic [15:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic REG_NACK,
	input wire logic ADAPTER_PRESENT,
	input wire logic [15:0] DISCHG_MA,
	input wire logic LOW_VSYS,
	input wire logic ALERT_PIN_O,
	input wire logic ALERT_PIN_OE_N,
	input wire logic [15:0] DC_THR_MA,
	input wire logic COMP_REF_ACTIVE,
	input wire logic CHARGE_EN,
	input wire logic TIMED_OUT,
	input wire dacr_pkg::dacr_cfg_s CFG_TRIM
);
	logic [9:0] vsys_cnt;
	logic [23:0] low_cnt;
	// Run length of low VSYS, saturating
	always_ff @(posedge CLK) begin
		if (SRST || !LOW_VSYS) vsys_cnt <= 10'h000;
		else if (vsys_cnt != 10'h3FF) vsys_cnt <= vsys_cnt + 10'h001;
	end
	// Cycles the alert has been driven
	always_ff @(posedge CLK) begin
		if (SRST || ALERT_PIN_OE_N) low_cnt <= 24'h000000;
		else low_cnt <= low_cnt + 24'h000001;
	end
	default clocking dc @(posedge CLK); endclocking
	default disable iff (SRST || !CE);
	AST_READ_ANSWER: assert property (REG_REQ.rd && !REG_REQ.wr |=> REG_RVALID ^ REG_NACK)
		else $error("read without single answer");
	AST_THR_READ: assert property (REG_REQ.rd && REG_REQ.cmd == dacr_pkg::CMD_DC_THR |=>
		REG_RVALID && REG_RDATA[7:0] == 8'h00 && REG_RDATA[15:14] == 2'h0)
		else $error("threshold readback has loose bits");
	AST_THR_CLAMP: assert property (DC_THR_MA <= 16'h3200)
		else $error("threshold above clamp");
	AST_INFO_RO: assert property (REG_REQ.wr && REG_REQ.cmd == dacr_pkg::CMD_INFO |=> REG_NACK)
		else $error("status write not refused");
	AST_ADAPTER_REF: assert property (ADAPTER_PRESENT [*3] |-> COMP_REF_ACTIVE)
		else $error("reference off with adapter");
	AST_VSYS_DEB_MIN: assert property ($fell(ALERT_PIN_OE_N) && DISCHG_MA == 16'h0000 |->
		vsys_cnt >= 10'h190) else $error("low VSYS alert too early");
	AST_VSYS_DEB_MAX: assert property (vsys_cnt == 10'h195 |-> !ALERT_PIN_OE_N)
		else $error("low VSYS alert missing");
	AST_HOLD_MIN: assert property ($rose(ALERT_PIN_OE_N) |-> $past(low_cnt) >= HOLD_UNIT_CYC)
		else $error("alert shorter than hold");
	AST_RELEASE: assert property ($rose(ALERT_PIN_OE_N) |->
		!($past(LOW_VSYS) && $past(LOW_VSYS, 2) && $past(LOW_VSYS, 3)))
		else $error("alert released with trigger present");
	AST_PIN_LOW: assert property (ALERT_PIN_O == 1'b0)
		else $error("alert pin data not low");
	AST_TMO_OFF: assert property ((!CFG_TRIM.tmo_en) [*3] |=> !$rose(TIMED_OUT))
		else $error("timeout while disabled");
	AST_TMO_STOP: assert property ($rose(TIMED_OUT) |-> ##[0:3] !CHARGE_EN)
		else $error("charging not stopped");
	AST_RESUME: assert property (REG_REQ.wr && REG_REQ.cmd == dacr_pkg::CMD_CHG_VOLT &&
		TIMED_OUT |-> ##[1:4] (CHARGE_EN && !TIMED_OUT)) else $error("charging not resumed");
	// Main scenarios reached
	cover property ($fell(ALERT_PIN_OE_N));
	cover property ($rose(TIMED_OUT));
	cover property (REG_NACK);
endmodule : dacr_top_sva

bind dacr_top dacr_top_sva #(.HOLD_UNIT_CYC(HOLD_UNIT_CYC)) u_sva (.CLK, .SRST, .CE, .REG_REQ,
	.REG_RDATA, .REG_RVALID, .REG_NACK, .ADAPTER_PRESENT, .DISCHG_MA, .LOW_VSYS, .ALERT_PIN_O,
	.ALERT_PIN_OE_N, .DC_THR_MA, .COMP_REF_ACTIVE, .CHARGE_EN, .TIMED_OUT, .CFG_TRIM);
